// ### inc/pmc_pkg.sv
`default_nettype none

package pmc_pkg;

    // ********
    // Timing
    // ********
    localparam int CLK_PERIOD_NS = 8;
    localparam int MDC_MAX_FREQ_MHZ = 8;
    localparam int RST_CYCLE_NS = 258000;
    localparam int RST_CYCLE_CYC = (RST_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 16;

    // ********
    // Serial frame counts and opcodes
    // ********
    localparam logic [5:0] PRE_BITS = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0c;
    localparam logic [5:0] DATA_LAST = 6'h0f;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;

    // ********
    // Management register map
    // ********
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CFG = 5'h10;
    localparam logic [4:0] REG_IEN = 5'h12;
    localparam logic [4:0] REG_IST = 5'h13;
    localparam int CTRL_RESET_BIT = 15;
    localparam int CTRL_LOOP_BIT = 14;
    localparam int CFG_MEDIA_BIT = 0;
    localparam int IEN_ENABLE_BIT = 1;
    localparam int IST_SD_BIT = 0;
    localparam int IST_LINK_BIT = 1;
    localparam int STRAP_W = 14;
    localparam logic [15:0] CFG_RST_VAL = 16'h0000;
    localparam logic [15:0] IEN_RST_VAL = 16'h0000;
    localparam logic [4:0] PHY_ADDR_RST = 5'h01;

    // ********
    // Bus register map
    // ********
    localparam int AXI_AW = 8;
    localparam logic [7:0] AXI_EVT_STATUS = 8'h00;
    localparam logic [7:0] AXI_EVT_MASK = 8'h04;
    localparam logic [7:0] AXI_STATE = 8'h08;
    localparam logic [7:0] AXI_PHY_ADDR = 8'h0c;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    localparam int EVT_WR = 0;
    localparam int EVT_RD = 1;
    localparam int EVT_IGN = 2;
    localparam int EVT_RST_DONE = 3;
    localparam int EVT_CHG = 4;
    localparam int EVT_W = 5;
    localparam logic [EVT_W-1:0] EVT_MASK_RST = 5'h00;

    typedef struct packed {
        logic [STRAP_W-1:0] straps;
        logic irq_n;
        logic sd;
        logic dis;
        logic mdio;
        logic mdc;
    } pmc_pins_t;

    typedef enum logic [2:0] {
        ST_PRE = 3'b000,
        ST_HDR = 3'b001,
        ST_TA = 3'b010,
        ST_RDATA = 3'b011,
        ST_WDATA = 3'b100
    } pmc_state_t;

endpackage

`default_nettype wire

// ### logic/pmc_rst_seq.sv
`timescale 1ns/10ps
`default_nettype none

module pmc_rst_seq #(
    parameter int CYCLES = pmc_pkg::RST_CYCLE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    import pmc_pkg::*;

    logic [RST_CNT_W-1:0] cnt_r;
    logic [RST_CNT_W-1:0] cnt_nxt;
    logic busy_r;
    logic done_r;
    wire last = (cnt_r == RST_CNT_W'(1));

    assign cnt_nxt = start ? RST_CNT_W'(CYCLES) : (cnt_r != '0) ? cnt_r - RST_CNT_W'(1) : cnt_r;
    assign busy = busy_r;
    assign done = done_r;

    // The cycle restarts from full on the pin and on the soft bit alike.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= RST_CNT_W'(CYCLES);
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= start | (cnt_nxt != '0);
            done_r <= last & ~start;
        end
    end

endmodule

`default_nettype wire

// ### logic/pmc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pmc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // A bit moves only once stages two and three agree.
    assign q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    assign q = q_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

endmodule

`default_nettype wire

// ### logic/pmc_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Disable input high blocks all serial reads and writes.
// - With management enabled, straps only set register defaults in reset.
// - After the reset cycle the serial channel owns those bits.
// - Both sides share the data line, each driving only its own part.
// - With bit 18.1 set, the interrupt pulls low on status change.
// - Reading register 19 clears pending status and releases the pin.
// - At reset the media input sets bit 16.0: high fiber, low twisted pair.
// - In fiber mode the media input is the fiber signal detect.
// - Reset pin low or control bit 0.15 starts a reset cycle.
// - The internal reset cycle runs 258 us after release.
module pmc_top #(
    parameter int RST_CYCLES = pmc_pkg::RST_CYCLE_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [pmc_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [pmc_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic MDC,
    input wire logic MDIO_I,
    output logic MDIO_O,
    output logic MDIO_OE,
    input wire logic MANAGEMENT_ACCESS_DISABLE,
    input wire logic SIGNAL_DETECT_MEDIA_SELECT,
    input wire logic [pmc_pkg::STRAP_W-1:0] CONFIG_STRAPS,
    input wire logic MANAGEMENT_INTERRUPT_N_I,
    output logic MANAGEMENT_INTERRUPT_N_O,
    output logic MANAGEMENT_INTERRUPT_N_OE,
    input wire logic LINK_STATUS,
    output logic LOOPBACK,
    output logic FIBER_MODE,
    output logic SIGNAL_DETECT,
    output logic RESET_BUSY,
    output logic IRQ
);
    import pmc_pkg::*;

    // ********
    // Pin sampling and reset cycle
    // ********
    pmc_pins_t pins_raw;
    pmc_pins_t pins;
    logic busy;
    logic rst_done;
    logic soft_rst;
    logic mdc_d_r;
    logic link_d_r;

    assign pins_raw.straps = CONFIG_STRAPS;
    assign pins_raw.irq_n = MANAGEMENT_INTERRUPT_N_I;
    assign pins_raw.sd = SIGNAL_DETECT_MEDIA_SELECT;
    assign pins_raw.dis = MANAGEMENT_ACCESS_DISABLE;
    assign pins_raw.mdio = MDIO_I;
    assign pins_raw.mdc = MDC;

    // Edges are found by oversampling, so MDC must stay far below CLOCK.
    pmc_sync #(
        .W($bits(pmc_pins_t))
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .d(pins_raw),
        .q(pins)
    );

    // The pin holds the sequencer in reset; the control bit restarts it.
    pmc_rst_seq #(
        .CYCLES(RST_CYCLES)
    ) u_rst (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .start(soft_rst),
        .busy(busy),
        .done(rst_done)
    );

    wire mdc_rise = pins.mdc & ~mdc_d_r;
    wire bit_in = pins.mdio;

    // ********
    // Serial frame engine
    // ********
    pmc_state_t st_r;
    pmc_state_t st_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [15:0] sh_r;
    logic [15:0] sh_nxt;
    logic [4:0] addr_r;
    logic [4:0] addr_nxt;
    logic rd_r;
    logic rd_nxt;
    logic oe_r;
    logic oe_nxt;
    logic o_r;
    logic o_nxt;
    logic wr_go;
    logic rd_go;
    logic ign_go;
    logic [15:0] rdata;
    logic [4:0] phy_addr_r;

    wire [12:0] hdr = {sh_r[11:0], bit_in};
    wire hdr_op_ok = (hdr[11:10] == OP_WRITE) | (hdr[11:10] == OP_READ);
    wire hdr_match = hdr[12] & hdr_op_ok & (hdr[9:5] == phy_addr_r);
    wire [15:0] wdata = {sh_r[14:0], bit_in};
    wire in_frame = (st_r == ST_TA) | (st_r == ST_RDATA) | (st_r == ST_WDATA);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        oe_nxt = oe_r;
        o_nxt = o_r;
        wr_go = 1'b0;
        rd_go = 1'b0;
        ign_go = 1'b0;
        if (busy) begin
            // No frame before the reset cycle ends.
            st_nxt = ST_PRE;
            cnt_nxt = '0;
            oe_nxt = 1'b0;
            o_nxt = 1'b1;
        end else if (pins.dis && in_frame) begin
            // Disable mid-frame drops the frame and frees the line.
            st_nxt = ST_PRE;
            cnt_nxt = '0;
            oe_nxt = 1'b0;
            o_nxt = 1'b1;
        end else if (mdc_rise) begin
            unique case (st_r)
                ST_PRE: begin
                    if (bit_in) begin
                        cnt_nxt = (cnt_r == PRE_BITS) ? cnt_r : cnt_r + 6'h01;
                    end else if (cnt_r == PRE_BITS) begin
                        st_nxt = ST_HDR;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = '0;
                    end
                end
                ST_HDR: begin
                    sh_nxt = {sh_r[14:0], bit_in};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == HDR_LAST) begin
                        cnt_nxt = '0;
                        addr_nxt = hdr[4:0];
                        rd_nxt = (hdr[11:10] == OP_READ);
                        if (!hdr_match) begin
                            st_nxt = ST_PRE;
                        end else if (pins.dis) begin
                            st_nxt = ST_PRE;
                            ign_go = 1'b1;
                        end else begin
                            st_nxt = ST_TA;
                        end
                    end
                end
                ST_TA: begin
                    if (cnt_r == '0) begin
                        cnt_nxt = 6'h01;
                        oe_nxt = rd_r;
                        o_nxt = ~rd_r;
                    end else begin
                        cnt_nxt = '0;
                        if (rd_r) begin
                            st_nxt = ST_RDATA;
                            sh_nxt = rdata;
                            o_nxt = rdata[15];
                            rd_go = 1'b1;
                        end else begin
                            st_nxt = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (cnt_r == DATA_LAST) begin
                        st_nxt = ST_PRE;
                        cnt_nxt = '0;
                        oe_nxt = 1'b0;
                        o_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 6'h01;
                        sh_nxt = {sh_r[14:0], 1'b0};
                        o_nxt = sh_r[14];
                    end
                end
                ST_WDATA: begin
                    sh_nxt = wdata;
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == DATA_LAST) begin
                        st_nxt = ST_PRE;
                        cnt_nxt = '0;
                        wr_go = 1'b1;
                    end
                end
                default: begin
                    st_nxt = ST_PRE;
                    cnt_nxt = '0;
                    oe_nxt = 1'b0;
                    o_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= ST_PRE;
            cnt_r <= '0;
            sh_r <= '0;
            addr_r <= '0;
            rd_r <= 1'b0;
            oe_r <= 1'b0;
            o_r <= 1'b1;
            mdc_d_r <= 1'b0;
            link_d_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            oe_r <= oe_nxt;
            o_r <= o_nxt;
            mdc_d_r <= pins.mdc;
            link_d_r <= LINK_STATUS;
        end
    end

    assign MDIO_O = o_r;
    assign MDIO_OE = oe_r;

    // ********
    // Management registers
    // ********
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    logic [15:0] ien_r;
    logic [15:0] ien_nxt;
    logic [15:0] ist_r;
    logic [15:0] ist_nxt;
    logic [15:0] ist_set;
    logic sd_det_r;

    wire wr_ctrl = wr_go & (addr_r == REG_CTRL);
    wire wr_cfg = wr_go & (addr_r == REG_CFG);
    wire wr_ien = wr_go & (addr_r == REG_IEN);
    wire rd_ist = rd_go & (addr_r == REG_IST);
    wire fiber = cfg_r[CFG_MEDIA_BIT];
    wire sd_det_nxt = fiber & pins.sd & ~busy;

    assign soft_rst = wr_ctrl & wdata[CTRL_RESET_BIT];

    assign rdata = (addr_r == REG_CTRL) ? {busy, ctrl_r[14:0]} :
                   (addr_r == REG_CFG) ? cfg_r :
                   (addr_r == REG_IEN) ? ien_r :
                   (addr_r == REG_IST) ? ist_r : 16'h0000;

    // While the disable is high the straps keep steering; otherwise they only seed the cycle.
    assign ctrl_nxt = (busy | pins.dis) ? {2'b00, pins.straps} :
                      wr_ctrl ? {1'b0, wdata[14:0]} : ctrl_r;
    // The media input is caught all through reset; the last value sticks.
    assign cfg_nxt = busy ? {CFG_RST_VAL[15:1], pins.sd} : wr_cfg ? wdata : cfg_r;
    assign ien_nxt = busy ? IEN_RST_VAL : wr_ien ? wdata : ien_r;

    assign ist_set[IST_SD_BIT] = sd_det_nxt ^ sd_det_r;
    assign ist_set[IST_LINK_BIT] = (LINK_STATUS ^ link_d_r) & ~busy;
    assign ist_set[15:2] = '0;
    // A change in the cycle of the clearing read survives.
    assign ist_nxt = busy ? 16'h0000 : ((rd_ist ? 16'h0000 : ist_r) | ist_set);

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_r <= '0;
            cfg_r <= CFG_RST_VAL;
            ien_r <= IEN_RST_VAL;
            ist_r <= '0;
            sd_det_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            ien_r <= ien_nxt;
            ist_r <= ist_nxt;
            sd_det_r <= sd_det_nxt;
        end
    end

    wire management_interrupt_n_active = ien_r[IEN_ENABLE_BIT] & (ist_r != 16'h0000);

    assign MANAGEMENT_INTERRUPT_N_O = 1'b0;
    assign MANAGEMENT_INTERRUPT_N_OE = management_interrupt_n_active;
    assign LOOPBACK = ctrl_r[CTRL_LOOP_BIT];
    assign FIBER_MODE = fiber;
    assign SIGNAL_DETECT = sd_det_r;
    assign RESET_BUSY = busy;

    // ********
    // Bus slave, events and interrupt
    // ********
    logic aw_have_r;
    logic w_have_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [EVT_W-1:0] evt_r;
    logic [EVT_W-1:0] mask_r;

    wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_hs = S_AXI_WVALID & S_AXI_WREADY;
    wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
    wire aw_ok = aw_have_r | aw_hs;
    wire w_ok = w_have_r | w_hs;
    wire bus_wr = aw_ok & w_ok & ~bvalid_r;
    wire [AXI_AW-1:0] wa = aw_have_r ? awaddr_r : S_AXI_AWADDR;
    wire [31:0] wd = w_have_r ? wdata_r : S_AXI_WDATA;
    wire ws0 = w_have_r ? wstrb0_r : S_AXI_WSTRB[0];
    wire wa_map = (wa == AXI_EVT_STATUS) | (wa == AXI_EVT_MASK) | (wa == AXI_STATE) | (wa == AXI_PHY_ADDR);
    wire ra_map = (S_AXI_ARADDR == AXI_EVT_STATUS) | (S_AXI_ARADDR == AXI_EVT_MASK) |
                  (S_AXI_ARADDR == AXI_STATE) | (S_AXI_ARADDR == AXI_PHY_ADDR);
    wire [EVT_W-1:0] evt_set = {|ist_set, rst_done, ign_go, rd_go, wr_go};
    wire [EVT_W-1:0] evt_w1c = (bus_wr && wa == AXI_EVT_STATUS && ws0) ? wd[EVT_W-1:0] : '0;
    wire [31:0] state_word = {26'h0, management_interrupt_n_active, ~pins.irq_n, busy, pins.dis, sd_det_r, fiber};
    wire [31:0] rmux = (S_AXI_ARADDR == AXI_EVT_STATUS) ? {27'h0, evt_r} :
                       (S_AXI_ARADDR == AXI_EVT_MASK) ? {27'h0, mask_r} :
                       (S_AXI_ARADDR == AXI_STATE) ? state_word :
                       (S_AXI_ARADDR == AXI_PHY_ADDR) ? {27'h0, phy_addr_r} : 32'h0;

    assign S_AXI_AWREADY = ~aw_have_r & ~bvalid_r;
    assign S_AXI_WREADY = ~w_have_r & ~bvalid_r;
    assign S_AXI_ARREADY = ~rvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign IRQ = |(evt_r & mask_r);

    // Address and data come in either order; the first waits in a holding register.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= AXI_OKAY;
        end else begin
            aw_have_r <= aw_ok & ~bus_wr;
            w_have_r <= w_ok & ~bus_wr;
            awaddr_r <= wa;
            wdata_r <= wd;
            wstrb0_r <= ws0;
            bvalid_r <= bus_wr | (bvalid_r & ~S_AXI_BREADY);
            bresp_r <= bus_wr ? (wa_map ? AXI_OKAY : AXI_SLVERR) : bresp_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= AXI_OKAY;
        end else begin
            rvalid_r <= ar_hs | (rvalid_r & ~S_AXI_RREADY);
            rdata_r <= ar_hs ? rmux : rdata_r;
            rresp_r <= ar_hs ? (ra_map ? AXI_OKAY : AXI_SLVERR) : rresp_r;
        end
    end

    // A new event outranks a clearing write to the same bit.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            evt_r <= '0;
            mask_r <= EVT_MASK_RST;
            phy_addr_r <= PHY_ADDR_RST;
        end else begin
            evt_r <= (evt_r & ~evt_w1c) | evt_set;
            mask_r <= (bus_wr && wa == AXI_EVT_MASK && ws0) ? wd[EVT_W-1:0] : mask_r;
            phy_addr_r <= (bus_wr && wa == AXI_PHY_ADDR && ws0) ? wd[4:0] : phy_addr_r;
        end
    end

endmodule

`default_nettype wire

// ### tb/phy_mgmt_control_pins_test.sv
`timescale 1ns/10ps
`default_nettype none

// ********
// Bench
// ********
module phy_mgmt_control_pins_test;
    import pmc_pkg::*;
    localparam int RC = 50;
    logic clock = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, dis = 1'b0, sd = 1'b1, link = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [13:0] straps = 14'h1a5c;
    logic awready, wready, bvalid, arready, rvalid, mdc, c_o, c_oe, m_o, m_oe, i_o, i_oe;
    logic loopback, fiber, sig_det, busy, irq;
    logic [1:0] bresp, rresp, r;
    logic [15:0] d;
    int num_errors = 0, compares = 0;
    wire mdio = m_oe ? m_o : (c_oe ? c_o : 1'b1);
    wire int_line = i_oe ? i_o : 1'b1;
    pmc_top #(.RST_CYCLES(RC)) i_dut (.CLOCK(clock), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MDC(mdc),
        .MDIO_I(mdio), .MDIO_O(m_o), .MDIO_OE(m_oe), .MANAGEMENT_ACCESS_DISABLE(dis),
        .SIGNAL_DETECT_MEDIA_SELECT(sd), .CONFIG_STRAPS(straps), .MANAGEMENT_INTERRUPT_N_I(int_line),
        .MANAGEMENT_INTERRUPT_N_O(i_o), .MANAGEMENT_INTERRUPT_N_OE(i_oe), .LINK_STATUS(link),
        .LOOPBACK(loopback), .FIBER_MODE(fiber), .SIGNAL_DETECT(sig_det), .RESET_BUSY(busy), .IRQ(irq));
    pmc_mgmt_ctrl i_mgmt (.mdc(mdc), .mdio_o(c_o), .mdio_oe(c_oe), .mdio(mdio));
    initial forever #4 clock = ~clock;
    task check(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task final_report;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        final_report;
    end
    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        do begin
            @(posedge clock);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        if (n >= 100) num_errors++;
        r = bresp;
        bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clock);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge clock);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        if (n >= 100) num_errors++;
        {q, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task t_reset(input int lo, input logic [31:0] ev);
        int n;
        logic [13:0] s;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clock);
            n++;
        end
        check("busy span", 32'h1, 32'(n >= lo && n <= RC + 3));
        check("fiber strap", 32'h1, 32'(fiber));
        axi_rd(AXI_EVT_STATUS);
        check("reset event", ev, q);
        s = straps;
        straps <= ~s;
        i_mgmt.frame(OP_READ, 5'h01, REG_CTRL, 16'h0, d);
        check("reg0 default", 32'(s), 32'(d));
    endtask
    task t_rw;
        // Signal detect stays high across the loopback phase.
        i_mgmt.frame(OP_WRITE, 5'h01, REG_CTRL, 16'h4123, d);
        check("loopback", 32'h1, 32'(loopback));
        i_mgmt.frame(OP_READ, 5'h01, REG_CTRL, 16'h0, d);
        check("reg0 written", 32'h4123, 32'(d));
        i_mgmt.frame(OP_READ, 5'h02, REG_CTRL, 16'h0, d);
        check("foreign addr", 32'hffff, 32'(d));
        i_mgmt.frame(OP_WRITE, 5'h01, REG_CTRL, 16'h0, d);
        axi_rd(AXI_EVT_STATUS);
        check("frame events", 32'h3, 32'(q[1:0]));
        axi_wr(AXI_EVT_STATUS, 32'h1f);
        axi_rd(AXI_EVT_STATUS);
        check("status cleared", 32'h0, q);
    endtask
    task t_dis;
        dis <= 1'b1;
        i_mgmt.frame(OP_WRITE, 5'h01, REG_CFG, 16'h0, d);
        i_mgmt.frame(OP_READ, 5'h01, REG_CFG, 16'h0, d);
        check("disabled read", 32'hffff, 32'(d));
        check("disabled write", 32'h1, 32'(fiber));
        dis <= 1'b0;
        axi_wr(AXI_EVT_MASK, 32'h4);
        repeat (2) @(posedge clock);
        check("irq raised", 32'h1, 32'(irq));
        axi_wr(AXI_EVT_STATUS, 32'h4);
        repeat (2) @(posedge clock);
        check("irq cleared", 32'h0, 32'(irq));
        axi_rd(8'h10);
        check("unmapped rd", 32'(AXI_SLVERR), 32'(r));
        axi_wr(8'h20, 32'h1);
        check("unmapped wr", 32'(AXI_SLVERR), 32'(r));
    endtask
    task t_irq;
        link <= 1'b1;
        repeat (8) @(posedge clock);
        check("pin idle", 32'h1, 32'(int_line));
        i_mgmt.frame(OP_READ, 5'h01, REG_IST, 16'h0, d);
        check("link event", 32'h1, 32'(d[IST_LINK_BIT]));
        i_mgmt.frame(OP_WRITE, 5'h01, REG_IEN, 16'h0002, d);
        link <= 1'b0;
        repeat (8) @(posedge clock);
        check("pin low", 32'h0, 32'(int_line));
        link <= 1'b1;
        repeat (40) @(posedge clock);
        check("pin latched", 32'h0, 32'(int_line));
        i_mgmt.frame(OP_READ, 5'h01, REG_IST, 16'h0, d);
        check("status read", 32'h1, 32'(d[IST_LINK_BIT]));
        check("pin released", 32'h1, 32'(int_line));
    endtask
    task t_media;
        sd <= 1'b0;
        repeat (8) @(posedge clock);
        check("sd low", 32'h0, 32'(sig_det));
        sd <= 1'b1;
        repeat (8) @(posedge clock);
        check("sd high", 32'h1, 32'(sig_det));
        axi_wr(AXI_EVT_STATUS, 32'h1f);
        i_mgmt.frame(OP_WRITE, 5'h01, REG_CTRL, 16'h8000, d);
        check("soft reset", 32'h1, 32'(busy));
        t_reset(RC - 6, 32'h19);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        t_reset(RC - 1, 32'h18);
        t_rw;
        t_dis;
        t_irq;
        t_media;
        final_report;
    end
endmodule

`default_nettype wire

// ### tb/pmc_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// ********
// Port checker
// ********
module pmc_assertions #(
    parameter int RST_CYCLES = pmc_pkg::RST_CYCLE_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic MDIO_O,
    input wire logic MDIO_OE,
    input wire logic MANAGEMENT_ACCESS_DISABLE,
    input wire logic MANAGEMENT_INTERRUPT_N_O,
    input wire logic MANAGEMENT_INTERRUPT_N_OE,
    input wire logic RESET_BUSY,
    input wire logic FIBER_MODE,
    input wire logic SIGNAL_DETECT,
    input wire logic SIGNAL_DETECT_MEDIA_SELECT
);
    import pmc_pkg::*;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    int busy_cnt;
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= RESET_BUSY ? busy_cnt + 1 : 0;
        end
    end
    a_busy_span: assert property ($fell(RESET_BUSY) |-> busy_cnt >= RST_CYCLES - 1 && busy_cnt <= RST_CYCLES + 1)
        else $error("reset length");
    a_busy_quiet: assert property (RESET_BUSY |-> !MDIO_OE)
        else $error("drive in reset");
    a_dis_quiet: assert property (MANAGEMENT_ACCESS_DISABLE [*8] |-> !MDIO_OE)
        else $error("drive while disabled");
    a_ta_zero: assert property ($rose(MDIO_OE) |-> !MDIO_O)
        else $error("turnaround not 0");
    a_oe_holds: assert property ($rose(MDIO_OE) |=> MDIO_OE [*8])
        else $error("read drive too short");
    a_od_low: assert property (!MANAGEMENT_INTERRUPT_N_O)
        else $error("pin drives high");
    a_clear_read: assert property ($fell(MANAGEMENT_INTERRUPT_N_OE) |-> MDIO_OE || RESET_BUSY)
        else $error("release without read");
    a_media_strap: assert property ($fell(RESET_BUSY) |-> FIBER_MODE == SIGNAL_DETECT_MEDIA_SELECT)
        else $error("media strap");
    a_sd_fiber: assert property (SIGNAL_DETECT |-> $past(FIBER_MODE && !RESET_BUSY))
        else $error("detect outside fiber");
    a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("bvalid dropped");
    cover property ($rose(MDIO_OE));
    cover property ($rose(MANAGEMENT_INTERRUPT_N_OE));
    cover property ($fell(RESET_BUSY));
endmodule

bind pmc_top pmc_assertions #(.RST_CYCLES(RST_CYCLES)) i_chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE),
    .MANAGEMENT_ACCESS_DISABLE(MANAGEMENT_ACCESS_DISABLE), .MANAGEMENT_INTERRUPT_N_O(MANAGEMENT_INTERRUPT_N_O),
    .MANAGEMENT_INTERRUPT_N_OE(MANAGEMENT_INTERRUPT_N_OE), .RESET_BUSY(RESET_BUSY), .FIBER_MODE(FIBER_MODE),
    .SIGNAL_DETECT(SIGNAL_DETECT), .SIGNAL_DETECT_MEDIA_SELECT(SIGNAL_DETECT_MEDIA_SELECT));

`default_nettype wire

// ### tb/pmc_mgmt_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// ********
// Station controller model
// ********
module pmc_mgmt_ctrl (
    output logic mdc,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic mdio
);
    import pmc_pkg::*;
    // A 128 ns period stays under 8 MHz.
    localparam int HALF = 64;
    initial begin
        mdc = 1'b0;
        mdio_oe = 1'b0;
        mdio_o = 1'b1;
    end
    // MDC rests low between frames.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            mdc = 1'b0;
            mdio_oe = !(op == OP_READ && i < 18);
            mdio_o = f[i];
            #HALF;
            if (i < 16) rd[i] = mdio;
            mdc = 1'b1;
            #HALF;
        end
        mdc = 1'b0;
        mdio_oe = 1'b0;
    endtask
endmodule

`default_nettype wire
